// file: rtl/irtx_cfg.svh
// constants for the infrared transmit fifo control block
// ------------------------------------------------------------
// Summary of operation
// - writing one to flush bit empties fifos; bit returns to zero itself
// - loopback bit one enters internal loopback, zero restores normal mode
// - fifo depth 32 bytes each direction, 16 bytes in loopback
// - level field selects threshold 1/1, 3/7, 7/17, 13/25 bytes
// - run-length enable bit turns run-length encoding of tx bytes on
// - run-length byte: bit 7 line value, bits 6-0 run length minus one
// - deferral holds tx data until time-out or fifo full
// - tx low-level interrupt when tx count below threshold, if enabled
// - rx data interrupt when rx count above threshold, if enabled
// ------------------------------------------------------------
`ifndef IRTX_CFG_SVH
`define IRTX_CFG_SVH
`define IRTX_ADDR_CTRL1   8'h0c
`define IRTX_ADDR_IRQEN   8'h10
`define IRTX_ADDR_STAT    8'h14
`define IRTX_ADDR_MASK    8'h18
`define IRTX_ADDR_LEVEL   8'h1c
`define IRTX_BIT_FLUSH    7
`define IRTX_BIT_LOOP     6
`define IRTX_BIT_LVL_HI   5
`define IRTX_BIT_LVL_LO   4
`define IRTX_BIT_RLE      3
`define IRTX_BIT_DEFER    2
`define IRTX_CTRL_RST     8'h00
`define IRTX_CTRL_WMASK   8'h7c
`define IRTX_DEPTH_NORM   6'd32
`define IRTX_DEPTH_LOOP   6'd16
`define IRTX_TOUT_US      40
`define IRTX_CLK_MHZ      25
`define IRTX_TOUT_CYC     (`IRTX_TOUT_US * `IRTX_CLK_MHZ)
`define IRTX_BIT_US       100
`define IRTX_BITT_CYC     (`IRTX_BIT_US * `IRTX_CLK_MHZ)
`define IRTX_RESP_OKAY    2'b00
`define IRTX_RESP_SLVERR  2'b10
`endif

// file: rtl/irtx_pkg.sv
// types for the infrared transmit fifo control block
package irtx_pkg;
  typedef enum logic [2:0] {
    IRTX_IDLE = 3'b001,
    IRTX_HOLD = 3'b010,
    IRTX_SEND = 3'b100
  } irtx_state_e;
  typedef struct packed {
    logic       flush;
    logic       loop;
    logic [1:0] level;
    logic       rle;
    logic       defer;
  } irtx_ctrl_s;
endpackage

// file: rtl/irtx_fifo_ctrl.sv
// infrared transmit fifo control with axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "irtx_cfg.svh"
module irtx_fifo_ctrl
  import irtx_pkg::*;
#(
  parameter int TOUT_CYC = `IRTX_TOUT_CYC,
  parameter int BITT_CYC = `IRTX_BITT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  input  wire logic        i_ir_rx,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_valid,
  input  wire logic        i_rx_ready,
  output logic             o_ir_tx,
  output logic             o_irq
);

  // ------------------------------------------------------------
  // storage and registers
  // ------------------------------------------------------------
  logic [7:0]  tx_mem [0:31];
  logic [7:0]  rx_mem [0:31];
  logic [4:0]  tx_rd_r, tx_wr_r, rx_rd_r, rx_wr_r;
  logic [5:0]  tx_cnt_r, rx_cnt_r;
  irtx_ctrl_s  ctrl_r;
  logic [1:0]  irq_en_r, stat_r, mask_r;
  logic [1:0]  rx_sync_r;
  irtx_state_e st_r;
  logic [31:0] tout_r, bitt_r;
  logic [7:0]  cur_r;
  logic [6:0]  run_r;
  logic [2:0]  bit_idx_r;
  logic [7:0]  rx_sh_r;
  logic [2:0]  rx_bits_r;
  logic [31:0] rx_bitt_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_lane0_r;

  // fifo depth and threshold from mode
  function automatic logic [5:0] depth_of(input logic loop);
    return loop ? `IRTX_DEPTH_LOOP : `IRTX_DEPTH_NORM;
  endfunction

  function automatic logic [5:0] thresh_of(input logic [1:0] lv,
                                           input logic loop);
    unique case (lv)
      2'b00: thresh_of = 6'd1;
      2'b01: thresh_of = loop ? 6'd3 : 6'd7;
      2'b10: thresh_of = loop ? 6'd7 : 6'd17;
      2'b11: thresh_of = loop ? 6'd13 : 6'd25;
    endcase
  endfunction

  logic [5:0] depth, thresh;
  logic       tx_full, rx_full, tx_pop, rx_push, rx_pop, tx_push;
  logic       wr_go, flush_wr;
  logic [7:0] rx_byte;
  logic [7:0] tx_head;

  assign depth   = depth_of(ctrl_r.loop);
  assign thresh  = thresh_of(ctrl_r.level, ctrl_r.loop);
  assign tx_full = tx_cnt_r >= depth;
  assign rx_full = rx_cnt_r >= depth;
  assign tx_push = i_tx_valid && !tx_full;
  assign o_tx_ready = !tx_full && !flush_wr;
  assign rx_pop  = o_rx_valid && i_rx_ready;
  assign o_rx_valid = rx_cnt_r != 6'd0;
  assign o_rx_data  = rx_mem[rx_rd_r];
  assign tx_head    = tx_mem[tx_rd_r];

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  assign o_awready = !aw_hold_r && !o_bvalid;
  assign o_wready  = !w_hold_r && !o_bvalid;
  assign wr_go     = aw_hold_r && w_hold_r && !o_bvalid;
  // flush request is a one-cycle strobe, never stored
  assign flush_wr  = wr_go && aw_addr_r == `IRTX_ADDR_CTRL1 && w_lane0_r
                     && w_data_r[`IRTX_BIT_FLUSH];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `IRTX_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_r  <= 1'b1;
        w_data_r  <= i_wdata;
        w_lane0_r <= i_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        unique case (aw_addr_r)
          `IRTX_ADDR_CTRL1, `IRTX_ADDR_IRQEN, `IRTX_ADDR_STAT,
          `IRTX_ADDR_MASK, `IRTX_ADDR_LEVEL: o_bresp <= `IRTX_RESP_OKAY;
          default: o_bresp <= `IRTX_RESP_SLVERR;
        endcase
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // control register; flush bit never held so it reads back zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_r   <= irtx_ctrl_s'(6'(`IRTX_CTRL_RST >> 2));
      irq_en_r <= 2'b00;
      mask_r   <= 2'b00;
    end else if (wr_go && w_lane0_r) begin
      unique case (aw_addr_r)
        // loopback, level, rle and deferral stored
        // flush masked off here: it acts through the strobe only
        `IRTX_ADDR_CTRL1:
          ctrl_r <= irtx_ctrl_s'(w_data_r[7:2]
                                 & 6'(`IRTX_CTRL_WMASK >> 2));
        `IRTX_ADDR_IRQEN: irq_en_r <= w_data_r[1:0];
        `IRTX_ADDR_MASK:  mask_r <= w_data_r[1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  assign o_arready = !o_rvalid;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `IRTX_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= `IRTX_RESP_OKAY;
      o_rdata  <= 32'h0000_0000;
      unique case (i_araddr)
        `IRTX_ADDR_CTRL1: o_rdata[7:0] <= {ctrl_r, 2'b00};
        `IRTX_ADDR_IRQEN: o_rdata[1:0] <= irq_en_r;
        `IRTX_ADDR_STAT:  o_rdata[1:0] <= stat_r;
        `IRTX_ADDR_MASK:  o_rdata[1:0] <= mask_r;
        `IRTX_ADDR_LEVEL: o_rdata[13:0] <= {rx_cnt_r, 2'b00, tx_cnt_r};
        default: o_rresp <= `IRTX_RESP_SLVERR;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupts: bit0 tx low level, bit1 rx data available
  // ------------------------------------------------------------
  logic [1:0] ev;
  assign ev[0] = irq_en_r[0] && tx_cnt_r < thresh;
  assign ev[1] = irq_en_r[1] && rx_cnt_r > thresh;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      stat_r <= 2'b00;
    else if (wr_go && w_lane0_r && aw_addr_r == `IRTX_ADDR_STAT)
      // set wins over the write-one clear
      stat_r <= (stat_r & ~w_data_r[1:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end
  assign o_irq = |(stat_r & mask_r);

  // ------------------------------------------------------------
  // tx fifo
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (tx_push)
      tx_mem[tx_wr_r] <= i_tx_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flush_wr) begin
      tx_wr_r  <= 5'd0;
      tx_rd_r  <= 5'd0;
      tx_cnt_r <= 6'd0;
    end else begin
      if (tx_push)
        tx_wr_r <= 5'(tx_wr_r + 5'd1 == depth[4:0] ? 5'd0 : tx_wr_r + 5'd1);
      if (tx_pop)
        tx_rd_r <= 5'(tx_rd_r + 5'd1 == depth[4:0] ? 5'd0 : tx_rd_r + 5'd1);
      tx_cnt_r <= 6'(tx_cnt_r + 6'(tx_push) - 6'(tx_pop));
    end
  end

  // ------------------------------------------------------------
  // transmitter: bit serial or run-length
  // ------------------------------------------------------------
  logic bit_tick, bit_last;
  assign bit_tick = bitt_r == 32'd0;
  assign bit_last = ctrl_r.rle ? run_r == 7'd0 : bit_idx_r == 3'd0;
  assign tx_pop   = (st_r != IRTX_SEND || (bit_tick && bit_last))
                    && tx_cnt_r != 6'd0
                    && !(ctrl_r.defer && st_r != IRTX_SEND
                         && !tx_full && tout_r != 32'd0);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flush_wr) begin
      st_r      <= IRTX_IDLE;
      tout_r    <= 32'(TOUT_CYC);
      bitt_r    <= 32'd0;
      cur_r     <= 8'h00;
      run_r     <= 7'd0;
      bit_idx_r <= 3'd0;
    end else begin
      // deferral holds data until time-out or fifo full
      if (st_r == IRTX_SEND || tx_push || tx_cnt_r == 6'd0)
        tout_r <= 32'(TOUT_CYC);
      else if (tout_r != 32'd0)
        tout_r <= tout_r - 32'd1;
      if (st_r == IRTX_SEND)
        bitt_r <= bit_tick ? 32'(BITT_CYC - 1) : bitt_r - 32'd1;
      if (tx_pop) begin
        st_r      <= IRTX_SEND;
        cur_r     <= tx_head;
        // low seven bits hold run length minus one
        run_r     <= tx_head[6:0];
        bit_idx_r <= 3'd7;
        bitt_r    <= 32'(BITT_CYC - 1);
      end else if (st_r == IRTX_SEND && bit_tick) begin
        if (bit_last)
          st_r <= ctrl_r.defer ? IRTX_HOLD : IRTX_IDLE;
        else if (ctrl_r.rle)
          run_r <= run_r - 7'd1;
        else
          bit_idx_r <= bit_idx_r - 3'd1;
      end else if (st_r != IRTX_SEND) begin
        st_r <= ctrl_r.defer && tx_cnt_r != 6'd0 ? IRTX_HOLD : IRTX_IDLE;
      end
    end
  end

  // rle sends bit 7 for the whole run
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_ir_tx <= 1'b0;
    else if (st_r != IRTX_SEND)
      o_ir_tx <= 1'b0;
    else
      o_ir_tx <= ctrl_r.rle ? cur_r[7] : cur_r[bit_idx_r];
  end

  // ------------------------------------------------------------
  // receiver: line in normal mode, tx output in loopback
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      rx_sync_r <= 2'b00;
    else
      rx_sync_r <= {rx_sync_r[0], i_ir_rx};
  end
  logic rx_bit;
  // loopback feeds tx output to receiver
  assign rx_bit  = ctrl_r.loop ? o_ir_tx : rx_sync_r[1];
  assign rx_byte = {rx_sh_r[6:0], rx_bit};
  // overflow drops bytes rather than stalling the line
  assign rx_push = rx_bitt_r == 32'd0 && rx_bits_r == 3'd7 && !rx_full;

  always_ff @(posedge i_clk) begin
    if (rx_push)
      rx_mem[rx_wr_r] <= rx_byte;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flush_wr) begin
      rx_sh_r   <= 8'h00;
      rx_bits_r <= 3'd0;
      rx_bitt_r <= 32'(BITT_CYC - 1);
      rx_wr_r   <= 5'd0;
      rx_rd_r   <= 5'd0;
      rx_cnt_r  <= 6'd0;
    end else begin
      if (rx_bitt_r == 32'd0) begin
        rx_bitt_r <= 32'(BITT_CYC - 1);
        rx_sh_r   <= rx_byte;
        rx_bits_r <= rx_bits_r + 3'd1;
      end else begin
        rx_bitt_r <= rx_bitt_r - 32'd1;
      end
      if (rx_push)
        rx_wr_r <= 5'(rx_wr_r + 5'd1 == depth[4:0] ? 5'd0 : rx_wr_r + 5'd1);
      if (rx_pop)
        rx_rd_r <= 5'(rx_rd_r + 5'd1 == depth[4:0] ? 5'd0 : rx_rd_r + 5'd1);
      rx_cnt_r <= 6'(rx_cnt_r + 6'(rx_push) - 6'(rx_pop));
    end
  end

endmodule

// file: test/irtx_fifo_ctrl_sva.sv
// assertion checker for the infrared transmit fifo control block
`timescale 1ns/1ns
`include "irtx_cfg.svh"
module irtx_fifo_ctrl_sva (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        o_tx_ready,
  input wire logic        o_rx_valid,
  input wire logic        o_ir_tx,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ------------------------------------------------------------
  // write steps
  // ------------------------------------------------------------
  sequence s_wr;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_flush;
    s_wr ##0 (i_awaddr == `IRTX_ADDR_CTRL1 && i_wdata[7] && i_wstrb[0]);
  endsequence
  // ready drops for the strobe, then the emptied fifo takes data again
  a_flush_ready: assert property (s_flush |-> ##1 !o_tx_ready ##1 o_tx_ready)
    else $error("flush did not empty tx fifo");
  a_flush_rx: assert property (s_flush |-> ##[1:4] !o_rx_valid)
    else $error("flush did not empty rx fifo");
  a_write_resp: assert property (s_wr |-> ##2 o_bvalid)
    else $error("write response late");
  a_unmapped_err: assert property (s_wr ##0 (i_awaddr > `IRTX_ADDR_LEVEL)
    |-> ##2 (o_bresp == `IRTX_RESP_SLVERR))
    else $error("unmapped write not refused");
  a_b_refuses: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
  a_b_drops: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response stuck");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_r_refuses: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  // reset itself is the antecedent, so no disable here
  a_reset_quiet: assert property (@(posedge i_clk) disable iff (1'b0)
    i_sys_rst |=> !o_irq && !o_ir_tx && !o_bvalid && !o_rvalid)
    else $error("outputs active after reset");
endmodule
bind irtx_fifo_ctrl irtx_fifo_ctrl_sva u_sva (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
  .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
  .o_ir_tx(o_ir_tx), .o_irq(o_irq));

// file: test/irtx_line_model.sv
// line-side model: drives the rx line, times high pulses on tx
`timescale 1ns/1ns
module irtx_line_model #(
  parameter int BITT = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_line,
  output logic             o_rx,
  output logic [15:0]      o_len,
  output logic             o_done
);
  logic [15:0] cnt_r = 16'h0000;
  logic [7:0]  ph_r  = 8'h00;
  initial o_rx = 1'b0;
  initial o_len = 16'h0000;
  initial o_done = 1'b0;
  // odd period so rx bytes vary against the bit grid
  always @(posedge i_clk) begin
    ph_r <= (ph_r == 8'(2 * BITT)) ? 8'h00 : ph_r + 8'h01;
    if (ph_r == 8'h00) o_rx <= ~o_rx;
  end
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_line) cnt_r <= cnt_r + 16'h0001;
    else begin
      if (cnt_r != 16'h0000) begin
        o_len  <= cnt_r;
        o_done <= 1'b1;
      end
      cnt_r <= 16'h0000;
    end
  end
endmodule

// file: test/irtx_fifo_ctrl_tb.sv
// self-checking testbench for the infrared transmit fifo control block
`timescale 1ns/1ns
`include "irtx_cfg.svh"
module irtx_fifo_ctrl_tb;
  import irtx_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic txv = 0, rxr = 0, irrx, awr, wr, bv, arr, rv, txr, rxv, irtx, irq;
  logic [7:0] awa = 0, ara = 0, txd = 0, rxd;
  logic [31:0] wd = 0, rdata, seed = 32'd90571;
  logic [3:0] ws = 4'hf;
  logic [1:0] bresp, rresp;
  logic [15:0] plen;
  logic pdone;
  logic [31:0] q_r[$], q_b[$], q_p[$];
  int bad_count = 0, samples_checked = 0;
  always #20 clk = ~clk;
  irtx_fifo_ctrl #(.TOUT_CYC(4), .BITT_CYC(3)) u_dut (.i_clk(clk),
    .i_sys_rst(rst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
    .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(rry), .i_tx_data(txd), .i_tx_valid(txv),
    .o_tx_ready(txr), .i_ir_rx(irrx), .o_rx_data(rxd), .o_rx_valid(rxv),
    .i_rx_ready(rxr), .o_ir_tx(irtx), .o_irq(irq));
  irtx_line_model #(.BITT(3)) u_line (.i_clk(clk), .i_line(irtx),
    .o_rx(irrx), .o_len(plen), .o_done(pdone));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    q_b.push_back({30'h0, r});
    @(posedge clk);
    {awa, wd} <= {a, d};
    {awv, wv, bry} <= 3'b111;
    // no cycle limit here: only the watchdog ends a hung wait
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_r.push_back(e);
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'b11;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    txd <= b;
    txv <= 1'b1;
    forever begin
      @(posedge clk);
      if (txr) break;
    end
    txv <= 1'b0;
  endtask
  // deferral keeps the fifo from draining, so it fills to its depth
  task automatic fill(input int d);
    int n;
    n = 0;
    @(posedge clk);
    txv <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      if (!txr) break;
      n++;
      seed = xs(seed);
      txd <= seed[7:0];
      rxr <= seed[8];
    end
    txv <= 1'b0;
    chk("fill", d, n);
  endtask
  task automatic wait_p;
    while (q_p.size() > 0) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // watcher: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rv && rry && q_r.size() > 0) chk("rdata", q_r.pop_front(), rdata);
    if (bv && bry && q_b.size() > 0) chk("bresp", q_b.pop_front(), bresp);
    if (pdone && q_p.size() > 0) chk("pulse", q_p.pop_front(), plen);
  end
  initial begin
    #(40 * 20000);
    bad_count++;
    conclude();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`IRTX_ADDR_CTRL1, 32'h0);
    wrt(`IRTX_ADDR_CTRL1, 32'hbc, `IRTX_RESP_OKAY);
    rd(`IRTX_ADDR_CTRL1, 32'h3c);
    for (int i = 0; i < 8; i++) begin
      wrt(`IRTX_ADDR_CTRL1, i << 4, `IRTX_RESP_OKAY);
      rd(`IRTX_ADDR_CTRL1, i << 4);
    end
    // lane 0 off: neither flush nor field update may happen
    seed = xs(seed);
    ws <= {seed[3:1], 1'b0};
    wrt(`IRTX_ADDR_CTRL1, 32'hb0, `IRTX_RESP_OKAY);
    ws <= 4'hf;
    rd(`IRTX_ADDR_CTRL1, 32'h70);
    wrt(`IRTX_ADDR_CTRL1, 32'h80, `IRTX_RESP_OKAY);
    wrt(8'h20, 32'h1, `IRTX_RESP_SLVERR);
    q_p.push_back(32'd12);
    push(8'h3c);
    wait_p();
    wrt(`IRTX_ADDR_CTRL1, 32'h08, `IRTX_RESP_OKAY);
    q_p.push_back(32'd3);
    q_p.push_back(32'd384);
    push(8'h80);
    push(8'h00);
    push(8'hff);
    push(8'h00);
    wait_p();
    wrt(`IRTX_ADDR_IRQEN, 32'h3, `IRTX_RESP_OKAY);
    wrt(`IRTX_ADDR_MASK, 32'h3, `IRTX_RESP_OKAY);
    rd(`IRTX_ADDR_STAT, 32'h3);
    chk("irq", 32'h1, irq);
    wrt(`IRTX_ADDR_MASK, 32'h0, `IRTX_RESP_OKAY);
    chk("irq", 32'h0, irq);
    wrt(`IRTX_ADDR_IRQEN, 32'h0, `IRTX_RESP_OKAY);
    wrt(`IRTX_ADDR_STAT, 32'h3, `IRTX_RESP_OKAY);
    wrt(`IRTX_ADDR_MASK, 32'h3, `IRTX_RESP_OKAY);
    rd(`IRTX_ADDR_STAT, 32'h0);
    chk("irq", 32'h0, irq);
    wrt(`IRTX_ADDR_CTRL1, 32'h84, `IRTX_RESP_OKAY);
    fill(32);
    wrt(`IRTX_ADDR_CTRL1, 32'hc4, `IRTX_RESP_OKAY);
    fill(16);
    wrt(`IRTX_ADDR_CTRL1, 32'h80, `IRTX_RESP_OKAY);
    // deferral below full: line stays idle until the time-out
    wrt(`IRTX_ADDR_CTRL1, 32'h04, `IRTX_RESP_OKAY);
    push(8'h80);
    repeat (3) @(posedge clk);
    chk("held", 32'h0, irtx);
    q_p.push_back(32'd3);
    wait_p();
    repeat (8) @(posedge clk);
    conclude();
  end
endmodule
